// >>> core/key_matrix_scanner_defs.vh
// Constants for the key matrix scanner: register map, fields, resets
// and timebase counts. Included by key_matrix_scanner.v and by the testbench.
`ifndef KEY_MATRIX_SCANNER_DEFS_VH
`define KEY_MATRIX_SCANNER_DEFS_VH

// ==========================================================
// Register byte offsets
`define KMS_CTRL_OFS 4'h0
`define KMS_STAT_OFS 4'h4
`define KMS_KEYS_OFS 4'h8

// ==========================================================
// Control register fields
`define KMS_CTRL_DIS 0
`define KMS_CTRL_SLP 1
`define KMS_CTRL_LVL_LO 2
`define KMS_CTRL_LVL_HI 4
`define KMS_CTRL_SRC 5
`define KMS_CTRL_PFN_LO 6
`define KMS_CTRL_PFN_HI 7
`define KMS_CTRL_RST 8'h00

// Status register fields
`define KMS_STAT_REQ 0
`define KMS_STAT_BUSY 1
`define KMS_STAT_SRST 2
`define KMS_STAT_DISP 3

// ==========================================================
// Timebase counts, in units of T, then scan line and key counts
`define KMS_SCAN_T 10'd288
`define KMS_SLOT_T 10'd48
`define KMS_REQ_T 10'd615
`define KMS_NLINES 6
`define KMS_NKEYS 30
// Core cycles per T for the internal oscillator
`define KMS_OSC_DIV 8'h04

// AXI responses
`define KMS_RESP_OK 2'h0
`define KMS_RESP_ERR 2'h2

`endif

// >>> core/key_matrix_scanner.v
// Key matrix scanner: six scan lines, five sense inputs, two-pass
// debounce, read request on an open-drain output, serial read link.
// Assumes an AXI4-Lite master on core_clk; all pins are asynchronous.
//
// Notes on behaviour
// - One scan lasts 288 timebase units of the selected clock.
// - Two scans run; a key is accepted only when both patterns agree.
// - Read request goes low 615 units after scan start.
// - Mismatching scans with a key still down start a fresh scan.
// - Scan lines follow the level field; low lines get no pulses.
// - A press on a high line starts scanning; repeats until release.
// - Simultaneous presses set every matching key bit.
// - Chip enable high in a write transfer forces serial output high.
// - Completed key read releases request and starts another scan.
// - In sleep a press restarts the timebase before scanning.
// - Key read in sleep clears request, rescans, sleep stays.
// - Scan disable set means no scan whatever key is pressed.
// - Setting scan disable aborts a running scan at once.
// - Scan disable with request pending clears keys, releases output.
// - Writing scan disable as zero lets scanning resume.
// - System reset turns display off, stops scans, clears keys.
// - Reset release turns display on and allows scanning.
// - Reset releases on chip enable fall ending a write transfer.
// - Key bit 5*(line-1)+sense, row-major over scan lines.
// - Lines one and two as segment outputs read keys 1-10 zero.
`timescale 1ns/1ps
`include "key_matrix_scanner_defs.vh"

module key_matrix_scanner (
    input wire core_clk,
    input wire srst,
    input wire [3:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [3:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire serialClockLine,
    input wire serialInLine,
    input wire chipEnable,
    input wire serialOutI,
    output wire serialOutO,
    output wire serialOutOe,
    input wire oscillatorPin,
    input wire supplyDetectReset,
    input wire [4:0] keySenseInputs,
    output reg [5:0] scanDriveLines,
    output wire displayOn,
    output wire timebaseRun
);

// ==========================================================
// States, one-hot
localparam S_IDLE = 3'h1;
localparam S_SCAN = 3'h2;
localparam S_REQ = 3'h4;

// ==========================================================
// Helpers

// True at the last unit of a 48-unit slot within a scan
function slotEnd;
    input [9:0] pos;
    integer k;
    begin
        slotEnd = 1'b0;
        for (k = 0; k < `KMS_NLINES; k = k + 1) begin
            if (pos == `KMS_SLOT_T * (k + 1) - 10'd1) begin
                slotEnd = 1'b1;
            end
        end
    end
endfunction

// Scan line under test for a position within one scan
function [2:0] lineOf;
    input [9:0] pos;
    integer k;
    begin
        lineOf = 3'h0;
        for (k = 1; k < `KMS_NLINES; k = k + 1) begin
            if (pos >= `KMS_SLOT_T * k) begin
                lineOf = k[2:0];
            end
        end
    end
endfunction

// ==========================================================
// Pin synchronisers, two flops before any logic
reg [9:0] sync1_ff;
reg [9:0] sync2_ff;
reg sclkDly_ff;
reg ceDly_ff;
reg oscDly_ff;

always @(posedge core_clk) begin
    if (srst) begin
        sync1_ff <= 10'h000;
        sync2_ff <= 10'h000;
        sclkDly_ff <= 1'b0;
        ceDly_ff <= 1'b0;
        oscDly_ff <= 1'b0;
    end else begin
        sync1_ff <= {supplyDetectReset, oscillatorPin, keySenseInputs,
            serialInLine, chipEnable, serialClockLine};
        sync2_ff <= sync1_ff;
        sclkDly_ff <= sync2_ff[0];
        ceDly_ff <= sync2_ff[1];
        oscDly_ff <= sync2_ff[8];
    end
end

wire sclkS = sync2_ff[0];
wire ceS = sync2_ff[1];
wire dinS = sync2_ff[2];
wire [4:0] senseS = sync2_ff[7:3];
wire oscS = sync2_ff[8];
wire supDetS = sync2_ff[9];
wire sclkRise = sclkS & ~sclkDly_ff;
wire sclkFall = ~sclkS & sclkDly_ff;
wire ceFall = ~ceS & ceDly_ff;
wire ceRise = ceS & ~ceDly_ff;

// ==========================================================
// Register file
reg [7:0] ctrl_ff;
reg [29:0] keyBuf_ff;
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg sysReset_ff;

wire scanDis = ctrl_ff[`KMS_CTRL_DIS];
wire sleepSel = ctrl_ff[`KMS_CTRL_SLP];
wire [2:0] lvlSel = ctrl_ff[`KMS_CTRL_LVL_HI:`KMS_CTRL_LVL_LO];
wire clkSrc = ctrl_ff[`KMS_CTRL_SRC];
wire [1:0] pinFn = ctrl_ff[`KMS_CTRL_PFN_HI:`KMS_CTRL_PFN_LO];

// AXI write: address and data taken in either order
reg awHeld_ff;
reg wHeld_ff;
reg [3:0] awAddr_ff;
reg [31:0] wData_ff;
reg [3:0] wStrb_ff;

assign awready = ~awHeld_ff & ~bvalid;
assign wready = ~wHeld_ff & ~bvalid;
assign arready = ~rvalid;

always @(posedge core_clk) begin
    if (srst) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        awAddr_ff <= 4'h0;
        wData_ff <= 32'h00000000;
        wStrb_ff <= 4'h0;
        bvalid <= 1'b0;
        bresp <= `KMS_RESP_OK;
        ctrl_ff <= `KMS_CTRL_RST;
    end else begin
        if (awvalid && awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end
        if (wvalid && wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
        end
        if (awHeld_ff && wHeld_ff && !bvalid) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bvalid <= 1'b1;
            if (awAddr_ff == `KMS_CTRL_OFS) begin
                bresp <= `KMS_RESP_OK;
                // Disable and its clearing act from the next cycle
                if (wStrb_ff[0]) begin
                    ctrl_ff <= wData_ff[7:0];
                end
            end else if (awAddr_ff == `KMS_STAT_OFS ||
                         awAddr_ff == `KMS_KEYS_OFS) begin
                bresp <= `KMS_RESP_OK; // Read-only, write ignored
            end else begin
                bresp <= `KMS_RESP_ERR;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
end

// AXI read, answer one cycle after the address is taken
always @(posedge core_clk) begin
    if (srst) begin
        rvalid <= 1'b0;
        rdata <= 32'h00000000;
        rresp <= `KMS_RESP_OK;
    end else if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `KMS_RESP_OK;
        case (araddr)
            `KMS_CTRL_OFS: rdata <= {24'h000000, ctrl_ff};
            `KMS_STAT_OFS: rdata <= {28'h0000000, ~sysReset_ff,
                sysReset_ff, ~state_ff[0], state_ff[2]};
            `KMS_KEYS_OFS: rdata <= {2'h0, keyBuf_ff};
            default: begin
                rdata <= 32'h00000000;
                rresp <= `KMS_RESP_ERR;
            end
        endcase
    end else if (rvalid && rready) begin
        rvalid <= 1'b0;
    end
end

// ==========================================================
// Serial link: first bit picks direction, 1 reads key data
reg inFrame_ff;
reg isRead_ff;
reg gotDir_ff;
reg [30:0] shift_ff;
reg shiftValid_ff;

always @(posedge core_clk) begin
    if (srst) begin
        inFrame_ff <= 1'b0;
        isRead_ff <= 1'b0;
        gotDir_ff <= 1'b0;
        shift_ff <= 31'h00000000;
        shiftValid_ff <= 1'b0;
    end else if (ceRise) begin
        inFrame_ff <= 1'b1;
        gotDir_ff <= 1'b0;
        isRead_ff <= 1'b0;
        shiftValid_ff <= 1'b0;
        shift_ff <= {sleepSel, keyBuf_ff}; // Sleep ack after key bits
    end else if (ceFall) begin
        inFrame_ff <= 1'b0;
        shiftValid_ff <= 1'b0;
    end else if (inFrame_ff) begin
        if (sclkRise && !gotDir_ff) begin
            gotDir_ff <= 1'b1;
            isRead_ff <= dinS;
        end
        // Key bits leave low bit first on falling clock edges
        if (sclkFall && gotDir_ff && isRead_ff) begin
            if (shiftValid_ff) begin
                shift_ff <= {1'b1, shift_ff[30:1]};
            end
            shiftValid_ff <= 1'b1;
        end
    end
end

wire readDone = ceFall & isRead_ff & ~sysReset_ff;
wire writeEnd = ceFall & gotDir_ff & ~isRead_ff;

// System reset: held until a write transfer ends after supply is good
always @(posedge core_clk) begin
    if (srst) begin
        sysReset_ff <= 1'b1;
    end else if (supDetS) begin
        sysReset_ff <= 1'b1;
    end else if (writeEnd) begin
        sysReset_ff <= 1'b0;
    end
end

assign displayOn = ~sysReset_ff;

// Output: open drain, enable pulls the line low
reg pullLow;
always @* begin
    pullLow = 1'b0;
    if (sysReset_ff) begin
        pullLow = 1'b0;
    end else if (inFrame_ff && gotDir_ff && !isRead_ff) begin
        pullLow = 1'b0;
    end else if (inFrame_ff && shiftValid_ff) begin
        pullLow = ~shift_ff[0];
    end else begin
        pullLow = state_ff[2];
    end
end

assign serialOutO = 1'b0;
assign serialOutOe = pullLow;

// ==========================================================
// Timebase: internal divider or external clock edges
reg [7:0] oscCnt_ff;
wire tbAllowed = ~sysReset_ff & (~sleepSel | ~state_ff[0]);
assign timebaseRun = tbAllowed;
wire intTick = (oscCnt_ff == `KMS_OSC_DIV - 8'h01);
wire tick = tbAllowed & (clkSrc ? (oscS & ~oscDly_ff) : intTick);

always @(posedge core_clk) begin
    if (srst || !tbAllowed || intTick) begin
        oscCnt_ff <= 8'h00; // Restarted oscillator begins a full period
    end else begin
        oscCnt_ff <= oscCnt_ff + 8'h01;
    end
end

// ==========================================================
// Scan line levels; code n holds lines n+1 to 6 high
reg [5:0] lineHigh;
reg [29:0] keyMask;
integer li;
always @* begin
    lineHigh = 6'h00;
    keyMask = 30'h3FFFFFFF;
    for (li = 0; li < `KMS_NLINES; li = li + 1) begin
        lineHigh[li] = (li >= lvlSel);
    end
    // Lines used as segment outputs carry no keys
    if (pinFn[0]) begin
        lineHigh[0] = 1'b0;
        keyMask[4:0] = 5'h00;
    end
    if (pinFn[1]) begin
        lineHigh[1] = 1'b0;
        keyMask[9:5] = 5'h00;
    end
end

// ==========================================================
// Scan sequencer
reg [9:0] tcnt_ff;
reg [29:0] scanCur_ff;
reg [29:0] scanPrev_ff;
wire anyPress = |senseS;
wire secondPass = (tcnt_ff >= `KMS_SCAN_T);
wire [9:0] scanPos = secondPass ? tcnt_ff - `KMS_SCAN_T : tcnt_ff;
wire [2:0] curLine = lineOf(scanPos);
wire inScanWin = (tcnt_ff < `KMS_SCAN_T + `KMS_SCAN_T);
wire startOk = anyPress & ~scanDis & ~sysReset_ff;
wire lastTick = tick & (tcnt_ff == `KMS_REQ_T - 10'd1);
wire match = (scanCur_ff == scanPrev_ff) & (|scanCur_ff);

// Next state of the sequencer
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        S_IDLE: begin
            if (startOk) begin
                nxt_state = S_SCAN;
            end
        end
        S_SCAN: begin
            if (scanDis || sysReset_ff) begin
                nxt_state = S_IDLE;
            end else if (lastTick && match) begin
                nxt_state = S_REQ;
            end else if (lastTick && !anyPress) begin
                nxt_state = S_IDLE;
            end
        end
        S_REQ: begin
            if (scanDis || sysReset_ff) begin
                nxt_state = S_IDLE;
            end else if (readDone) begin
                nxt_state = S_SCAN;
            end
        end
        default: nxt_state = S_IDLE;
    endcase
end

// Counter, scan results and key buffer
always @(posedge core_clk) begin
    if (srst) begin
        state_ff <= S_IDLE;
        tcnt_ff <= 10'd0;
        scanCur_ff <= 30'h00000000;
        scanPrev_ff <= 30'h00000000;
        keyBuf_ff <= 30'h00000000;
    end else begin
        state_ff <= nxt_state;
        if (nxt_state == S_SCAN && state_ff != S_SCAN) begin
            tcnt_ff <= 10'd0;
            scanCur_ff <= 30'h00000000;
        end else if (state_ff == S_SCAN && tick) begin
            tcnt_ff <= tcnt_ff + 10'd1;
            // Sample at slot end; every pressed key sets its bit
            if (inScanWin && slotEnd(scanPos) && lineHigh[curLine]) begin
                scanCur_ff[curLine * 5 +: 5] <= senseS;
            end
            if (tcnt_ff == `KMS_SCAN_T - 10'd1) begin
                scanPrev_ff <= scanCur_ff;
            end else if (tcnt_ff == `KMS_SCAN_T) begin
                scanCur_ff <= 30'h00000000;
            end
            if (lastTick && !match && anyPress) begin
                tcnt_ff <= 10'd0;
                scanCur_ff <= 30'h00000000;
            end
        end
        // The first-pass sample at position 287 lands in the same edge
        // as the copy, so the copy takes the freshly sampled slot too
        if (state_ff == S_SCAN && tick && tcnt_ff == `KMS_SCAN_T - 10'd1 &&
            lineHigh[curLine]) begin
            scanPrev_ff <= scanCur_ff | ({25'h0000000, senseS}
                << (curLine * 5));
        end
        if (sysReset_ff || (scanDis && state_ff == S_REQ)) begin
            keyBuf_ff <= 30'h00000000;
        end else if (state_ff == S_SCAN && nxt_state == S_REQ) begin
            keyBuf_ff <= scanCur_ff & keyMask;
        end
    end
end

// ==========================================================
// Scan line drive: one pulse per high line while scanning
always @(posedge core_clk) begin
    if (srst || sysReset_ff) begin
        scanDriveLines <= 6'h00;
    end else if (state_ff == S_SCAN && inScanWin) begin
        scanDriveLines <= lineHigh & (6'h01 << curLine);
    end else begin
        scanDriveLines <= lineHigh;
    end
end

endmodule // key_matrix_scanner

// >>> dv/key_matrix_scanner_sva.sv
// Checker for the key matrix scanner: read answers, request timing,
// reset states. Bound to the top module and sees its ports only.
`timescale 1ns/1ps

module key_matrix_scanner_sva (
    input wire core_clk,
    input wire srst,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire serialOutO,
    input wire serialOutOe,
    input wire displayOn,
    input wire [5:0] scanDriveLines,
    input wire supplyDetectReset,
    input wire chipEnable,
    input wire serialClockLine,
    input wire serialInLine
);
    logic ceQ_ff, clQ_ff, clP_ff, dirDone_ff, isRead_ff;
    logic [11:0] lowCnt_ff;
    logic [7:0] ceGap_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ==========================================================
    // Helper logic
    // Pin samples and frame direction, as the host sets it
    always_ff @(posedge core_clk) begin
        ceQ_ff <= chipEnable;
        clQ_ff <= serialClockLine;
        clP_ff <= clQ_ff;
        if (srst) begin
            dirDone_ff <= 1'b0;
            isRead_ff <= 1'b0;
        end else if (!ceQ_ff) begin
            dirDone_ff <= 1'b0;
        end else if (clQ_ff && !clP_ff && !dirDone_ff) begin
            dirDone_ff <= 1'b1;
            isRead_ff <= serialInLine;
        end
    end

    // Saturating counts: line released, frames closed
    always_ff @(posedge core_clk) begin
        if (srst || serialOutOe) lowCnt_ff <= 12'h000;
        else if (lowCnt_ff != 12'hFFF) lowCnt_ff <= lowCnt_ff + 12'h001;
        if (srst || ceQ_ff) ceGap_ff <= 8'h00;
        else if (ceGap_ff != 8'hFF) ceGap_ff <= ceGap_ff + 8'h01;
    end

    sequence s_inWrite;
        ceQ_ff && dirDone_ff && !isRead_ff;
    endsequence

    sequence s_readEnd;
        $fell(ceQ_ff) && isRead_ff && displayOn;
    endsequence

    // ==========================================================
    // Assertions
    AST_RVALID: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_OPEN_DRAIN: assert property (serialOutO == 1'b0)
        else $error("serial output drives high");
    AST_RST_DISP: assert property (
        supplyDetectReset |-> ##[1:6] !displayOn)
        else $error("display stays on in reset");
    AST_RST_LINES: assert property (
        !displayOn [*3] |-> scanDriveLines == 6'h00)
        else $error("scan lines driven in reset");
    AST_RST_NO_REQ: assert property (!displayOn [*4] |-> !serialOutOe)
        else $error("request pulled in reset");
    AST_WR_FRAME: assert property (s_inWrite [*4] |-> !serialOutOe)
        else $error("line pulled during a write frame");
    AST_READ_RELEASE: assert property (
        s_readEnd |-> ##[1:8] (!serialOutOe) [*8])
        else $error("request not released after read");
    AST_REQ_DELAY: assert property (
        $rose(serialOutOe) && ceGap_ff > 8'd16 |-> lowCnt_ff >= 12'd2400)
        else $error("request too soon after scan start");
endmodule // key_matrix_scanner_sva

bind key_matrix_scanner key_matrix_scanner_sva u_sva (
    .core_clk(core_clk), .srst(srst), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .serialOutO(serialOutO),
    .serialOutOe(serialOutOe), .displayOn(displayOn),
    .scanDriveLines(scanDriveLines), .supplyDetectReset(supplyDetectReset),
    .chipEnable(chipEnable), .serialClockLine(serialClockLine),
    .serialInLine(serialInLine)
);

// >>> dv/key_link_host.sv
// Host model on the three-wire key link: read and write frames.
// Assumes a pulled-up wire level on lineLevel; link clock 125 ns.
`timescale 1ns/1ps

module key_link_host (
    output logic chipEnable,
    output logic serialClockLine,
    output logic serialInLine,
    input wire lineLevel
);
    localparam realtime HALF = 62.5;

    // ==========================================================
    // Frames
    // Link clock rests low outside frames
    initial begin
        chipEnable = 1'b0;
        serialClockLine = 1'b0;
        serialInLine = 1'b0;
    end

    // Read frame: direction 1, then 30 key bits and sleep ack
    task read_frame(output logic [29:0] keys, output logic ack,
                    output logic many);
        logic [30:0] sh;
        int i;
        begin
            serialInLine = 1'b1;
            chipEnable = 1'b1;
            #HALF;
            serialClockLine = 1'b1;
            for (i = 0; i < 31; i++) begin
                #HALF;
                serialClockLine = 1'b0;
                serialInLine = ~serialInLine; // Unused after direction
                #HALF;
                serialClockLine = 1'b1;
                sh[i] = lineLevel;
            end
            #HALF;
            serialClockLine = 1'b0;
            #HALF;
            chipEnable = 1'b0; // Completes the read
            keys = sh[29:0];
            ack = sh[30];
            many = $countones(sh[29:0]) >= 3; // Discard hint
        end
    endtask

    // Write frame: direction 0 and seven more bits; its end lifts reset
    task write_frame(output logic sawLow);
        int i;
        begin
            sawLow = 1'b0;
            serialInLine = 1'b0;
            chipEnable = 1'b1;
            for (i = 0; i < 8; i++) begin
                #HALF;
                serialClockLine = 1'b1;
                #HALF;
                sawLow = sawLow | ~lineLevel; // Direction bit already seen
                serialClockLine = 1'b0;
                serialInLine = i[0];
            end
            #HALF;
            chipEnable = 1'b0; // Last block delivered
            #HALF;
        end
    endtask
endmodule // key_link_host

// >>> dv/key_matrix_scanner_tb.sv
// Testbench for the key matrix scanner: AXI register tasks, a key
// matrix, and the link host model. Assumes 125 MHz core clock.
`timescale 1ns/1ps
`include "key_matrix_scanner_defs.vh"

module key_matrix_scanner_tb;
    logic core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, d;
    wire awready, wready, bvalid, arready, rvalid, serialOutO, serialOutOe;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire chipEnable, serialClockLine, serialInLine, displayOn, timebaseRun;
    wire [5:0] scanDriveLines;
    logic oscillatorPin, supplyDetectReset, sa, many, low;
    logic [4:0] keySenseInputs;
    logic [29:0] pressed, k;
    logic [5:0] lv;
    logic [1:0] lastResp;
    int err_total, checked, n, c;
    wire serialLine = serialOutOe ? 1'b0 : 1'b1; // Pull-up on the wire

    key_matrix_scanner dut (.core_clk(core_clk), .srst(srst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .serialClockLine(serialClockLine),
        .serialInLine(serialInLine), .chipEnable(chipEnable),
        .serialOutI(serialLine), .serialOutO(serialOutO),
        .serialOutOe(serialOutOe), .oscillatorPin(oscillatorPin),
        .supplyDetectReset(supplyDetectReset),
        .keySenseInputs(keySenseInputs), .scanDriveLines(scanDriveLines),
        .displayOn(displayOn), .timebaseRun(timebaseRun));
    key_link_host host (.chipEnable(chipEnable),
        .serialClockLine(serialClockLine), .serialInLine(serialInLine),
        .lineLevel(serialLine));

    // ==========================================================
    // Clocks and key matrix
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        oscillatorPin = 1'b0;
        forever #20 oscillatorPin = ~oscillatorPin;
    end
    // A sense input sees a pressed key only while its line is high
    always @(posedge core_clk) begin
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < 6; i++)
            if (scanDriveLines[i]) s |= pressed[5*i +: 5];
        keySenseInputs <= s;
    end

    // ==========================================================
    // Tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, got;
        begin
            @(posedge core_clk);
            {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
            got = 1'b0;
            for (n = 0; !got; n++) begin
                @(negedge core_clk);
                {ta, tw, got, lastResp} = {awready, wready, bvalid, bresp};
                @(posedge core_clk);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
            end
            bready <= 1'b0;
        end
    endtask
    task rd(input logic [3:0] a, output logic [31:0] v);
        logic ta, got;
        begin
            @(posedge core_clk);
            {araddr, arvalid, rready} <= {a, 2'h3};
            got = 1'b0;
            for (n = 0; !got; n++) begin
                @(negedge core_clk);
                {ta, got, v, lastResp} = {arready, rvalid, rdata, rresp};
                @(posedge core_clk);
                if (ta) arvalid <= 1'b0;
            end
            rready <= 1'b0;
        end
    endtask
    task cyc(input int m);
        repeat (m) @(negedge core_clk);
    endtask
    task press(input logic [29:0] v);
        @(posedge core_clk);
        pressed <= v;
    endtask
    // Bounded wait for the request; m is the limit, n the cycles seen
    task wait_req(input int m);
        for (n = 0; serialOutOe !== 1'b1 && n < m; n++) @(negedge core_clk);
    endtask
    task note(input string s);
        $display("Test %s ended: %0d checks, %0d errors", s, checked, err_total);
    endtask
    task test_done;
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, well above the expected run
    initial begin
        #800_000;
        err_total++;
        test_done;
    end

    // ==========================================================
    // Tests
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wstrb, wdata} = 44'h00F00000000;
        {supplyDetectReset, pressed} = 31'h00000000;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        rd(`KMS_STAT_OFS, d);
        chk(d, 32'h4);
        rd(4'hC, d);
        chk({lastResp, d[29:0]}, {`KMS_RESP_ERR, 30'h0});
        wr(4'hC, 32'h0);
        chk({30'h0, lastResp}, {30'h0, `KMS_RESP_ERR});
        host.write_frame(low);
        cyc(8);
        rd(`KMS_STAT_OFS, d);
        chk(d, 32'h8);
        note("reset");
        for (c = 0; c < 6; c++) begin
            wr(`KMS_CTRL_OFS, c << 2);
            cyc(8);
            lv = 6'h3F << c;
            chk(scanDriveLines, lv);
        end
        press(30'h1);
        wait_req(3000);
        chk(n, 3000);
        press(30'h20000001);
        wait_req(4000);
        chk(n >= 2455 && n <= 2500, 1);
        rd(`KMS_KEYS_OFS, d);
        chk(d, 32'h20000000);
        host.write_frame(low);
        chk(low, 0);
        host.read_frame(k, sa, many);
        chk({sa, k}, 31'h20000000);
        cyc(8);
        chk(serialOutOe, 0);
        wait_req(3000);
        chk(n < 3000, 1);
        wr(`KMS_CTRL_OFS, 32'h15);
        rd(`KMS_KEYS_OFS, d);
        chk({serialOutOe, d[30:0]}, 0);
        wait_req(3000);
        chk(n, 3000);
        wr(`KMS_CTRL_OFS, 32'h14);
        wait_req(4000);
        chk(n < 4000, 1);
        press(0);
        host.read_frame(k, sa, many);
        wait_req(3000);
        chk(n, 3000);
        note("lines");
        wr(`KMS_CTRL_OFS, 32'h0);
        press(30'h20000801);
        wait_req(4000);
        rd(`KMS_KEYS_OFS, d);
        chk(d, 32'h20000801);
        press(0);
        host.read_frame(k, sa, many);
        chk(many, 1);
        press(30'h400);
        cyc(1000);
        wr(`KMS_CTRL_OFS, 32'h1);
        rd(`KMS_STAT_OFS, d);
        chk(d[1], 0);
        wr(`KMS_CTRL_OFS, 32'hC0);
        press(30'h401);
        wait_req(4000);
        rd(`KMS_KEYS_OFS, d);
        chk(d, 32'h400);
        press(0);
        host.read_frame(k, sa, many);
        wr(`KMS_CTRL_OFS, 32'h0);
        press(30'h1);
        cyc(700);
        press(30'h2);
        wait_req(7000);
        chk(n >= 3000, 1);
        rd(`KMS_KEYS_OFS, d);
        chk(d, 32'h2);
        press(0);
        host.read_frame(k, sa, many);
        note("keys");
        wr(`KMS_CTRL_OFS, 32'h2);
        cyc(2600); // Rescan after the last read must end first
        chk(timebaseRun, 0);
        press(30'h2000000);
        wait_req(6000);
        chk(n < 6000, 1);
        host.read_frame(k, sa, many);
        chk({sa, k}, 31'h42000000);
        wait_req(4000);
        chk(n < 4000, 1);
        rd(`KMS_CTRL_OFS, d);
        chk(d, 32'h2);
        press(0);
        host.read_frame(k, sa, many);
        wr(`KMS_CTRL_OFS, 32'h20);
        press(30'h1);
        wait_req(6000);
        chk(n >= 3000 && n < 6000, 1);
        note("sleep");
        @(posedge core_clk);
        supplyDetectReset <= 1'b1;
        cyc(10);
        chk({displayOn, serialOutOe}, 0);
        rd(`KMS_KEYS_OFS, d);
        chk(d, 0);
        @(posedge core_clk);
        supplyDetectReset <= 1'b0;
        wait_req(3000);
        chk(n, 3000);
        host.read_frame(k, sa, many);
        cyc(8);
        chk(displayOn, 0);
        host.write_frame(low);
        wait_req(7000);
        chk({displayOn, n < 7000}, 2'h3);
        note("sysreset");
        test_done;
    end
endmodule // key_matrix_scanner_tb
